//--- inc/sld_pkg.sv
// Constants shared by the serial latched driver design.
// Assumes nothing of its surroundings; imported by the buffer and top-level design files.
package sld_pkg;

  // -----------------------------------------------------------------
  // Structure
  // -----------------------------------------------------------------
  localparam int unsigned SLD_STAGES    = 12; // Shift stages and outputs
  localparam int unsigned SLD_BUF_DEPTH = 2;  // Entries in the bit buffer
  localparam int unsigned SLD_BUF_CNT_W = 2;  // Width of the entry count

  // -----------------------------------------------------------------
  // Timing
  // -----------------------------------------------------------------
  localparam int unsigned SLD_CORE_CLK_NS  = 8;   // Core clock period
  localparam int unsigned SLD_LINK_CLK_NS  = 160; // Shift clock period
  // Core cycles per shift clock period, rounded down
  localparam int unsigned SLD_LINK_CYC =
    (SLD_LINK_CLK_NS / SLD_CORE_CLK_NS < 1) ? 1 :
    SLD_LINK_CLK_NS / SLD_CORE_CLK_NS;

  // -----------------------------------------------------------------
  // Reset values
  // -----------------------------------------------------------------
  localparam logic [SLD_STAGES-1:0] SLD_SHIFT_RST = 12'h000;
  localparam logic [SLD_STAGES-1:0] SLD_LATCH_RST = 12'h000;
  localparam logic [SLD_STAGES-1:0] SLD_PULL_RST  = 12'hfff;

endpackage : sld_pkg

//--- inc/sld_if.sv
// Valid/ready carrier between the bit sampler, the buffer and the
// shift stage. Assumes one clock domain, the core clock.
`timescale 1ns/1ps

interface sld_if #(
  parameter int unsigned WIDTH = 1
);
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;

  // Filling and draining side, and buffer
  modport fill  (output push_valid, output push_data, input push_ready,
                 input pop_valid, input pop_data, output pop_ready);
  modport store (input push_valid, input push_data, output push_ready,
                 output pop_valid, output pop_data, input pop_ready);
endinterface : sld_if

//--- core/sld_buf.sv
// Two-entry valid/ready buffer for sampled serial bits.
// Assumes synchronous active-low reset on the core clock.
`timescale 1ns/1ps

module sld_buf
  import sld_pkg::*;
#(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = sld_pkg::SLD_BUF_DEPTH
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Both sides of the buffer
  sld_if.store      bq
);

  // -----------------------------------------------------------------
  // Elaboration checks
  // -----------------------------------------------------------------
  if (DEPTH != 2 || WIDTH < 1) begin : g_bad_param
    $error("sld_buf serves two entries of at least one bit");
  end

  localparam logic [SLD_BUF_CNT_W-1:0] CNT_ZERO = 2'h0;
  localparam logic [SLD_BUF_CNT_W-1:0] CNT_ONE  = 2'h1;
  localparam logic [SLD_BUF_CNT_W-1:0] CNT_FULL = 2'h2;

  logic [SLD_BUF_CNT_W-1:0] cnt_ff;
  logic [WIDTH-1:0]         head_ff;
  logic [WIDTH-1:0]         tail_ff;
  logic [SLD_BUF_CNT_W-1:0] nxt_cnt;
  logic [WIDTH-1:0]         nxt_head;
  logic [WIDTH-1:0]         nxt_tail;
  wire                      push_fire;
  wire                      pop_fire;

  // -----------------------------------------------------------------
  // Handshakes and next state
  // -----------------------------------------------------------------
  // Honest flags straight from the count
  assign bq.push_ready = (cnt_ff != CNT_FULL);
  assign bq.pop_valid  = (cnt_ff != CNT_ZERO);
  assign bq.pop_data   = head_ff;
  assign push_fire     = bq.push_valid & bq.push_ready;
  assign pop_fire      = bq.pop_valid & bq.pop_ready;

  assign nxt_cnt = cnt_ff + SLD_BUF_CNT_W'(push_fire)
                   - SLD_BUF_CNT_W'(pop_fire);
  // Head refills from the tail when full, else from the new bit
  assign nxt_head = pop_fire ? ((cnt_ff == CNT_FULL) ? tail_ff
                                                     : bq.push_data)
                  : ((cnt_ff == CNT_ZERO) ? bq.push_data : head_ff);
  assign nxt_tail = (push_fire &&
                     ((cnt_ff == CNT_ONE && !pop_fire) ||
                      (cnt_ff == CNT_FULL && pop_fire)))
                  ? bq.push_data : tail_ff;

  // Storage registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_ff  <= CNT_ZERO;
      head_ff <= '0;
      tail_ff <= '0;
    end else begin
      cnt_ff  <= nxt_cnt;
      head_ff <= nxt_head;
      tail_ff <= nxt_tail;
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  chk_buf_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
    cnt_ff <= CNT_FULL)
    else $error("buffer count beyond two");

  chk_buf_order: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cnt_ff == CNT_FULL && pop_fire) |=> (head_ff == $past(tail_ff)))
    else $error("buffer lost word order");

endmodule : sld_buf

//--- core/sld_top.sv
// Serial-in, parallel-out latched driver controller, core logic.
// Assumes pins are asynchronous to core_clk and that the shift clock
// runs well below the core clock (period of several core cycles).
//
// Function
// [RULE_01] Twelve shift stages, each with one latch and one driver.
// [RULE_02] A rising shift clock loads the data pin level into stage one.
// [RULE_03] Each further rising shift clock moves every stage one on.
// [RULE_04] While latch enable is high each latch takes its stage.
// [RULE_05] Latches follow while enable stays high and hold once it drops.
// [RULE_06] With latch enable tied high the host keeps disable high; sld_host raises it while send_word shifts a word and when set_ctl sets it.
// [RULE_07] Disable high turns all sources off and all pull-downs on.
// [RULE_08] Disable never alters what the latches hold.
// [RULE_09] Disable low drives each output high or low from its latch.
// [RULE_10] The cascade output shows the last stage after each shift.
`timescale 1ns/1ps

module sld_top
  import sld_pkg::*;
#(
  parameter int unsigned STAGES = sld_pkg::SLD_STAGES
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // Serial link pins
  input  wire logic              shift_clk,
  input  wire logic              ser_din,
  input  wire logic              latch_en,
  input  wire logic              out_dis,
  // Cascade output
  output logic                   ser_dout_ff,
  // Output stage controls
  output logic [STAGES-1:0]      src_on_ff,
  output logic [STAGES-1:0]      pull_on_ff,
  // Bit lost because the buffer was full
  output logic                   overrun_ff
);

  // -----------------------------------------------------------------
  // Elaboration checks
  // -----------------------------------------------------------------
  if (STAGES != SLD_STAGES) begin : g_bad_param
    $error("sld_top reset constants serve twelve stages only");
  end

  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------
  logic [3:0] meta_ff;  // First flops, read only by the second rank
  logic [3:0] sync_ff;  // Second flops, safe to use
  logic       clk_prev_ff;

  // Two flops per pin; the shift clock is just sampled data here
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_ff     <= 4'h0;
      sync_ff     <= 4'h0;
      clk_prev_ff <= 1'b0;
    end else begin
      meta_ff     <= {out_dis, latch_en, ser_din, shift_clk};
      sync_ff     <= meta_ff;
      clk_prev_ff <= sync_ff[0];
    end
  end

  wire clk_s  = sync_ff[0];
  wire din_s  = sync_ff[1];
  wire le_s   = sync_ff[2];
  wire dis_s  = sync_ff[3];
  // Data and clock share synchroniser depth, so data is sampled at
  // the same core edge that sees the shift clock rise
  wire clk_rise = clk_s & ~clk_prev_ff;

  // -----------------------------------------------------------------
  // Bit buffer between sampler and shift stages
  // -----------------------------------------------------------------
  sld_if #(.WIDTH(1)) bq ();

  sld_buf #(
    .WIDTH (1),
    .DEPTH (SLD_BUF_DEPTH)
  ) u_buf (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .bq       (bq.store)
  );

  logic le_prev_ff;
  // Shift stalls for one cycle as the latch opens, so the first copy
  // sees a settled stage pattern; the buffer absorbs the held bit
  wire  le_open   = le_s & ~le_prev_ff;
  wire  shift_go  = bq.pop_valid & bq.pop_ready;

  assign bq.push_valid = clk_rise;                        // RULE_02
  assign bq.push_data  = din_s;                           // RULE_02
  assign bq.pop_ready  = ~le_open;

  // -----------------------------------------------------------------
  // Shift stages, latches and output stage
  // -----------------------------------------------------------------
  logic [STAGES-1:0] shift_ff;                            // RULE_01
  logic [STAGES-1:0] latch_ff;                            // RULE_01
  logic [STAGES-1:0] nxt_shift;
  logic [STAGES-1:0] nxt_latch;
  logic [STAGES-1:0] nxt_src;
  logic [STAGES-1:0] nxt_pull;
  logic              nxt_overrun;

  // New bit enters stage one, the rest move toward the cascade end
  assign nxt_shift = shift_go
                   ? {shift_ff[STAGES-2:0], bq.pop_data}  // RULE_02 RULE_03
                   : shift_ff;
  // Transparent while enabled, else holding; disable plays no part
  assign nxt_latch = le_s ? shift_ff : latch_ff;  // RULE_04 RULE_05 RULE_08
  // Blanking forces sources off and pull-downs on
  assign nxt_src   = dis_s ? '0 : latch_ff;               // RULE_07 RULE_09
  assign nxt_pull  = dis_s ? '1 : ~latch_ff;              // RULE_07 RULE_09
  // Sticky loss flag; a too-fast shift clock is the usual cause
  assign nxt_overrun = overrun_ff | (clk_rise & ~bq.push_ready);

  // Main registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      shift_ff    <= SLD_SHIFT_RST;
      latch_ff    <= SLD_LATCH_RST;
      src_on_ff   <= '0;
      pull_on_ff  <= SLD_PULL_RST;
      ser_dout_ff <= 1'b0;
      overrun_ff  <= 1'b0;
      le_prev_ff  <= 1'b0;
    end else begin
      shift_ff    <= nxt_shift;
      latch_ff    <= nxt_latch;
      src_on_ff   <= nxt_src;
      pull_on_ff  <= nxt_pull;
      ser_dout_ff <= nxt_shift[STAGES-1];                 // RULE_10
      overrun_ff  <= nxt_overrun;
      le_prev_ff  <= le_s;
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  chk_first_stage_load: // RULE_02
    assert property (@(posedge core_clk) disable iff (!rst_n)
      shift_go |=> (shift_ff[0] == $past(bq.pop_data)))
    else $error("stage one missed the sampled bit");

  chk_pin_to_stage: // RULE_02
    assert property (@(posedge core_clk) disable iff (!rst_n)
      // A latch opening one cycle on stalls the load, so it is left out
      (clk_rise && bq.push_ready && !bq.pop_valid && !le_s) ##1 !le_open
        |=> (shift_ff[0] == $past(din_s, 2)))
    else $error("rising shift clock did not load the data level");

  chk_stage_move: // RULE_03
    assert property (@(posedge core_clk) disable iff (!rst_n)
      shift_go |=> (shift_ff[STAGES-1:1] == $past(shift_ff[STAGES-2:0])))
    else $error("stages did not move on");

  chk_stage_hold: // RULE_03
    assert property (@(posedge core_clk) disable iff (!rst_n)
      !shift_go |=> $stable(shift_ff))
    else $error("stages changed without a shift");

  chk_latch_follow: // RULE_04
    assert property (@(posedge core_clk) disable iff (!rst_n)
      le_s |=> (latch_ff == $past(shift_ff)))
    else $error("open latch did not take its stage");

  chk_latch_keep: // RULE_05
    assert property (@(posedge core_clk) disable iff (!rst_n)
      (!le_s ##1 !le_s) |=> $stable(latch_ff))
    else $error("closed latch changed");

  chk_blank_keep: // RULE_08
    assert property (@(posedge core_clk) disable iff (!rst_n)
      ($changed(dis_s) && !le_s) |=> $stable(latch_ff))
    else $error("disable disturbed the latches");

  chk_blank_off: // RULE_07
    assert property (@(posedge core_clk) disable iff (!rst_n)
      dis_s |=> (src_on_ff == '0 && pull_on_ff == '1))
    else $error("outputs not forced off while disabled");

  chk_out_follow: // RULE_09
    assert property (@(posedge core_clk) disable iff (!rst_n)
      !dis_s |=> (src_on_ff == $past(latch_ff) &&
                  pull_on_ff == ~$past(latch_ff)))
    else $error("outputs do not follow the latches");

  chk_cascade_last: // RULE_10
    assert property (@(posedge core_clk) disable iff (!rst_n)
      shift_go |=> (ser_dout_ff == $past(shift_ff[STAGES-2])))
    else $error("cascade output differs from the last stage");

endmodule : sld_top

//--- testbench/sld_host.sv
// Host model: drives shift clock, serial data, latch enable, blanking.
// Assumes the bench core clock; every pin changes at its rising edge.
`timescale 1ns/1ps

module sld_host (
  // Bench clock
  input  wire logic core_clk,
  // Pins toward the device
  output logic      shift_clk,
  output logic      ser_din,
  output logic      latch_en,
  output logic      out_dis
);
  // Idle pins: shift clock stands low between frames
  initial begin
    shift_clk = 1'b0;
    ser_din   = 1'b0;
    latch_en  = 1'b0;
    out_dis   = 1'b0;
  end

  // One 160 ns link period; data leads the rise by 40 ns
  task automatic send_bit(input logic b);
    @(posedge core_clk) ser_din <= b;
    repeat (5) @(posedge core_clk);
    shift_clk <= 1'b1;
    repeat (10) @(posedge core_clk);
    shift_clk <= 1'b0;
    repeat (4) @(posedge core_clk);
    ser_din <= ~b; // Hold over: inverse, so a stale level cannot pass
  endtask : send_bit

  // Word goes out top bit first, so bit i lands in stage i
  task automatic send_word(input logic [sld_pkg::SLD_STAGES-1:0] w);
    logic keep_dis;
    // Read after the edge, so a level just set by set_ctl is seen
    @(posedge core_clk);
    keep_dis = out_dis;
    if (latch_en) begin
      out_dis <= 1'b1;
    end
    for (int i = sld_pkg::SLD_STAGES - 1; i >= 0; i--) begin
      send_bit(w[i]);
    end
    @(posedge core_clk) out_dis <= keep_dis;
  endtask : send_word

  // Latch enable and blanking levels
  task automatic set_ctl(input logic le, input logic od);
    @(posedge core_clk);
    latch_en <= le;
    out_dis  <= od;
  endtask : set_ctl
endmodule : sld_host

//--- testbench/test_serial_latched_driver_ctrl.sv
// Self-checking bench for the serial latched driver controller.
// Assumes the design package and the host model are compiled first.
`timescale 1ns/1ps

module test_serial_latched_driver_ctrl;
  import sld_pkg::*;
  logic                  core_clk;
  logic                  rst_n;
  logic                  shift_clk;
  logic                  ser_din;
  logic                  latch_en;
  logic                  out_dis;
  logic                  ser_dout_ff;
  logic                  overrun_ff;
  logic [SLD_STAGES-1:0] src_on_ff;
  logic [SLD_STAGES-1:0] pull_on_ff;
  logic [SLD_STAGES-1:0] w1;
  logic [SLD_STAGES-1:0] w2;
  int                    num_errors = 0;
  int                    checks_done = 0;

  // 125 MHz core clock
  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;

  sld_top u_sld_top (.core_clk(core_clk), .rst_n(rst_n),
    .shift_clk(shift_clk), .ser_din(ser_din), .latch_en(latch_en),
    .out_dis(out_dis), .ser_dout_ff(ser_dout_ff), .src_on_ff(src_on_ff),
    .pull_on_ff(pull_on_ff), .overrun_ff(overrun_ff));

  sld_host u_sld_host (.core_clk(core_clk), .shift_clk(shift_clk),
    .ser_din(ser_din), .latch_en(latch_en), .out_dis(out_dis));

  // ---------------------------------------------------------------
  // Compare and report
  // ---------------------------------------------------------------
  task automatic check_vec(input logic [SLD_STAGES-1:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check_vec

  task automatic check_bit(input logic got, exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check_bit

  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  // Sync and pipeline latency is a few cycles; 8 covers it
  task automatic settle;
    repeat (8) @(posedge core_clk);
    #1;
  endtask : settle

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic sc_reset;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    settle();
    check_vec(src_on_ff, 12'h000);
    check_vec(pull_on_ff, 12'hfff);
    check_bit(ser_dout_ff, 1'b0);
  endtask : sc_reset

  // Shift with latches closed, then open them once
  task automatic sc_shift_latch;
    u_sld_host.send_word(w1);
    settle();
    check_vec(src_on_ff, 12'h000);
    check_bit(ser_dout_ff, w1[11]);
    u_sld_host.set_ctl(1'b1, 1'b0);
    settle();
    check_vec(src_on_ff, w1);
    check_vec(pull_on_ff, ~w1);
    u_sld_host.set_ctl(1'b0, 1'b0);
  endtask : sc_shift_latch

  // Extra bits push older stages out of the cascade pin
  task automatic sc_cascade;
    for (int k = 10; k >= 8; k--) begin
      u_sld_host.send_bit(1'b0);
      settle();
      check_bit(ser_dout_ff, w1[k]);
    end
    check_vec(src_on_ff, w1);
  endtask : sc_cascade

  // Blanking forces outputs off but keeps latch contents
  task automatic sc_blank;
    u_sld_host.set_ctl(1'b0, 1'b1);
    settle();
    check_vec(src_on_ff, 12'h000);
    check_vec(pull_on_ff, 12'hfff);
    u_sld_host.send_word(w2);
    // Unblank with the latch closed: the old pattern must come back
    u_sld_host.set_ctl(1'b0, 1'b0);
    settle();
    check_vec(src_on_ff, w1);
    u_sld_host.set_ctl(1'b1, 1'b1);
    settle();
    check_vec(src_on_ff, 12'h000);
    u_sld_host.set_ctl(1'b0, 1'b1);
    u_sld_host.set_ctl(1'b0, 1'b0);
    settle();
    check_vec(src_on_ff, w2);
    check_vec(pull_on_ff, ~w2);
  endtask : sc_blank

  // Latch held open: outputs follow the register after entry
  task automatic sc_transparent;
    u_sld_host.set_ctl(1'b1, 1'b0);
    u_sld_host.send_word(w1 ^ w2);
    settle();
    check_vec(src_on_ff, w1 ^ w2);
    u_sld_host.set_ctl(1'b0, 1'b0);
    u_sld_host.send_word(12'hfff);
    settle();
    check_vec(src_on_ff, w1 ^ w2);
    check_bit(overrun_ff, 1'b0);
  endtask : sc_transparent

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    w1    = 12'ha5c;
    w2    = 12'h3c6;
    sc_reset();
    sc_shift_latch();
    sc_cascade();
    sc_blank();
    sc_transparent();
    final_report();
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    num_errors++;
    final_report();
  end
endmodule : test_serial_latched_driver_ctrl
